// [verilog/two_wire_port.sv]
// Device end of the two-wire command port: frame decoder, register bank,
// fixed commands, and the edge-triggered transmit and sleep control.
// Assumes the host owns i_sclk and keeps it high outside frames.
// How it works
// RL1: Word 0x8D02 over 16 bits is the port disable command.
// RL2: After disable, port ignores frames; data edges start transmission until port reset.
// RL3: Word 0xBD01 over 16 bits is the core soft reset command.
// RL4: Soft reset clears everything but the port, then starts calibration.
// RL5: Host waits at least 1 ms after soft reset; device then sleeps.
// RL6: Rising-edge start mode idles data low; no first-edge delay needed.
// RL7: Host changes data on rising clock; device samples on falling clock.
// RL8: Host holds the serial clock high while transmitting.
// RL9: Sleep after data low for the stop time, or on soft reset.
// RL10: Host should send port reset then soft reset right after data.
// RL11: Frames are 16 clocks; first 8 carry start, direction and address.
// RL12: Last 8 clocks: data is input on write, device drives on read.
// RL13: Data returns to idle level by the final rising clock edge.
// RL14: Frame opens with 1, then direction (1 read), then 6-bit address.
// RL15: Write frame 1,0,address,data; device stores the data byte.
// RL16: Read header 1,1,address; device shifts out the register content.
// RL17: Host releases data at the rising edge that opens the read phase.
// RL18: Port reset is decoded apart from the normal frame format.
// RL19: Port reset is 32 low clocks then 0x8D00; it revives the port.
// RL20: Falling-edge mode host delays the first falling clock edge.
// RL21: Bits travel most significant first.
`timescale 1ns/10ps
module two_wire_port
  import two_wire_pkg::*;
#(
  parameter int STOP_UNIT = STOP_UNIT_CYCLES
) (
  // Core clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Serial link from the host
  input wire logic i_sclk,
  input wire logic i_data,
  output logic o_data,
  output logic o_data_oe,
  // Transmit configuration
  input wire logic i_start_fall,
  input wire logic [6:0] i_stop_ms,
  // Register writes towards the core
  output logic o_reg_wr,
  output reg_wr_s o_reg,
  // Core control
  output logic o_core_rst_n,
  output logic o_cal_start,
  output logic o_port_en,
  output logic o_tx_start,
  output logic o_tx_active,
  output logic o_sleep
);

  // Link domain: falling edges of the serial clock do all decoding
  logic sclk_n;
  logic lrst_n;
  link_s lnk_r;
  link_s lnk_nxt;
  pin_s pin_r;
  logic [15:0] word;
  logic frame_done;
  logic hdr_done;
  logic is_read;

  assign sclk_n = ~i_sclk;

  // Power-on reset carried into the serial clock domain
  sync_2ff #(.W(1)) u_lrst (
    .i_clk(sclk_n),
    .i_d(i_rstn),
    .o_q(lrst_n)
  );

  assign word = {lnk_r.sh, i_data}; // see RL21
  assign frame_done = (lnk_r.st == ST_SHIFT) && (lnk_r.cnt == FRAME_LAST_BIT);
  assign hdr_done = (lnk_r.st == ST_SHIFT) && (lnk_r.cnt == HDR_LAST_BIT);
  assign is_read = lnk_r.sh[HDR_DIR_POS - 1]; // see RL14

  always_comb begin
    lnk_nxt = lnk_r;
    // Low-run counter saturates; a 1 restarts it
    if (i_data) begin
      lnk_nxt.lowrun = 6'h00;
    end else if (lnk_r.lowrun != RST_LOW_CYCLES) begin
      lnk_nxt.lowrun = lnk_r.lowrun + 6'h01;
    end
    case (lnk_r.st)
      ST_IDLE: begin
        // Every frame and command opens with a 1
        if (i_data) begin // see RL14
          lnk_nxt.st = ST_SHIFT;
          lnk_nxt.cnt = 5'h01;
          lnk_nxt.sh = 15'h0001;
          lnk_nxt.rst_seq = (lnk_r.lowrun == RST_LOW_CYCLES); // see RL19
        end
      end
      ST_SHIFT: begin
        lnk_nxt.sh = word[14:0];
        lnk_nxt.cnt = lnk_r.cnt + 5'h01;
        if (hdr_done && is_read && lnk_r.en && !lnk_r.rst_seq) begin // see RL16
          lnk_nxt.st = ST_READ;
          lnk_nxt.rd_sh = lnk_r.regs[word[5:0]];
        end else if (frame_done) begin // see RL11
          lnk_nxt.st = ST_IDLE;
          lnk_nxt.cnt = 5'h00;
          if (lnk_r.rst_seq && word == CMD_PORT_RST) begin // see RL18 RL19
            lnk_nxt.en = 1'b1;
          end else if (!lnk_r.en) begin
            lnk_nxt.en = 1'b0; // see RL2
          end else if (word == CMD_PORT_OFF) begin // see RL1
            lnk_nxt.en = 1'b0;
          end else if (word == CMD_SOFT_RST) begin // see RL3 RL4
            lnk_nxt.soft_tgl = ~lnk_r.soft_tgl;
            for (int i = 0; i < 64; i++) begin
              lnk_nxt.regs[i] = REG_RESET_VAL;
            end
          end else if (!word[HDR_DIR_POS + 8]) begin // see RL15
            lnk_nxt.regs[word[13:8]] = word[7:0];
            lnk_nxt.wr.addr = word[13:8];
            lnk_nxt.wr.data = word[7:0];
            lnk_nxt.wr_tgl = ~lnk_r.wr_tgl;
          end
        end
      end
      ST_READ: begin
        // Device owns the pin for the last eight clocks
        lnk_nxt.rd_sh = {lnk_r.rd_sh[6:0], 1'b0}; // see RL12 RL21
        lnk_nxt.cnt = lnk_r.cnt + 5'h01;
        if (lnk_r.cnt == FRAME_LAST_BIT) begin
          lnk_nxt.st = ST_IDLE;
          lnk_nxt.cnt = 5'h00;
        end
      end
      default: begin
        lnk_nxt.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(negedge i_sclk) begin // see RL7
    if (!lrst_n) begin
      lnk_r <= '{st: ST_IDLE, regs: '0, default: '0};
    end else begin
      lnk_r <= lnk_nxt;
    end
  end

  // Pin driver changes on rising edges so the host samples a settled bit
  always_ff @(posedge i_sclk) begin
    if (!lrst_n) begin
      pin_r <= '0;
    end else begin
      pin_r.oe <= (lnk_r.st == ST_READ); // see RL12 RL13
      pin_r.dout <= lnk_r.rd_sh[7];
    end
  end

  assign o_data = pin_r.dout;
  assign o_data_oe = pin_r.oe;

  // Core domain
  logic [3:0] xs;
  core_s cor_r;
  core_s cor_nxt;
  logic wr_evt;
  logic soft_evt;
  logic edge_evt;
  logic stop_done;

  // Toggles, enable and the raw pin level cross here; wr holds still meanwhile
  sync_2ff #(.W(4)) u_xs (
    .i_clk(i_clk),
    .i_d({lnk_r.wr_tgl, lnk_r.soft_tgl, lnk_r.en, i_data}),
    .o_q(xs)
  );

  assign wr_evt = xs[3] ^ cor_r.wr_q;
  assign soft_evt = xs[2] ^ cor_r.soft_q;
  // Edge detector only owns the pin while the port is off
  assign edge_evt = !xs[1] && !cor_r.active &&
                    (i_start_fall ? (cor_r.data_q && !xs[0]) : (!cor_r.data_q && xs[0])); // see RL2 RL6
  assign stop_done = cor_r.active && !xs[0] && (cor_r.unit_cnt == 17'(STOP_UNIT - 1)) &&
                     (cor_r.ms_cnt + 7'h01 >= i_stop_ms);

  always_comb begin
    cor_nxt = cor_r;
    cor_nxt.wr_q = xs[3];
    cor_nxt.soft_q = xs[2];
    cor_nxt.data_q = xs[0];
    cor_nxt.reg_wr = 1'b0;
    cor_nxt.tx_start = 1'b0;
    cor_nxt.cal_start = 1'b0;
    if (cor_r.rst_cnt != 3'h0) begin
      cor_nxt.rst_cnt = cor_r.rst_cnt - 3'h1;
    end
    if (wr_evt) begin
      cor_nxt.reg_wr = 1'b1;
      cor_nxt.wr = lnk_r.wr;
    end
    // Stop timer: whole units of 1 ms while the pin stays low
    if (!cor_r.active || xs[0]) begin
      cor_nxt.unit_cnt = 17'h00000;
      cor_nxt.ms_cnt = 7'h00;
    end else if (cor_r.unit_cnt == 17'(STOP_UNIT - 1)) begin
      cor_nxt.unit_cnt = 17'h00000;
      cor_nxt.ms_cnt = cor_r.ms_cnt + 7'h01;
    end else begin
      cor_nxt.unit_cnt = cor_r.unit_cnt + 17'h00001;
    end
    if (soft_evt) begin // see RL4 RL9
      cor_nxt.rst_cnt = CORE_RST_CYCLES;
      cor_nxt.cal_start = 1'b1;
      cor_nxt.active = 1'b0;
      cor_nxt.sleep = 1'b1;
      cor_nxt.unit_cnt = 17'h00000;
      cor_nxt.ms_cnt = 7'h00;
    end else if (stop_done) begin // see RL9
      cor_nxt.active = 1'b0;
      cor_nxt.sleep = 1'b1;
    end else if (edge_evt) begin // see RL2
      cor_nxt.active = 1'b1;
      cor_nxt.sleep = 1'b0;
      cor_nxt.tx_start = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      cor_r <= '{sleep: 1'b1, default: '0};
    end else begin
      cor_r <= cor_nxt;
    end
  end

  assign o_reg_wr = cor_r.reg_wr;
  assign o_reg = cor_r.wr;
  assign o_core_rst_n = (cor_r.rst_cnt == 3'h0);
  assign o_cal_start = cor_r.cal_start;
  assign o_port_en = xs[1];
  assign o_tx_start = cor_r.tx_start;
  assign o_tx_active = cor_r.active;
  assign o_sleep = cor_r.sleep;

  // Checks in the link domain
  sequence s_disable_word;
    frame_done && lnk_r.en && !lnk_r.rst_seq && word == CMD_PORT_OFF;
  endsequence

  sequence s_read_header;
    hdr_done && lnk_r.en && !lnk_r.rst_seq && is_read;
  endsequence

  a_port_off: assert property ( // see RL1 RL2
    @(negedge i_sclk) disable iff (!lrst_n)
    s_disable_word |=> !lnk_r.en)
    else $error("disable word did not turn the port off");

  a_off_ignores: assert property ( // see RL2
    @(negedge i_sclk) disable iff (!lrst_n)
    (!lnk_r.en && !(frame_done && lnk_r.rst_seq && word == CMD_PORT_RST)) |=>
      (!lnk_r.en && $stable(lnk_r.regs) && $stable(lnk_r.soft_tgl)))
    else $error("disabled port acted on a frame");

  a_soft_toggle: assert property ( // see RL3
    @(negedge i_sclk) disable iff (!lrst_n)
    (frame_done && lnk_r.en && !lnk_r.rst_seq && word == CMD_SOFT_RST) |=>
      (lnk_r.soft_tgl != $past(lnk_r.soft_tgl)) && lnk_r.st == ST_IDLE)
    else $error("soft reset word not decoded");

  a_port_revive: assert property ( // see RL18 RL19
    @(negedge i_sclk) disable iff (!lrst_n)
    (frame_done && lnk_r.rst_seq && word == CMD_PORT_RST) |=> lnk_r.en)
    else $error("port reset did not enable the port");

  a_write_store: assert property ( // see RL15
    @(negedge i_sclk) disable iff (!lrst_n)
    (frame_done && lnk_r.en && word[15:14] == 2'b10 && word != CMD_PORT_OFF &&
     word != CMD_SOFT_RST && !(lnk_r.rst_seq && word == CMD_PORT_RST)) |=>
      lnk_r.regs[$past(word[13:8])] == $past(word[7:0]))
    else $error("write frame did not store its byte");

  a_read_phase: assert property ( // see RL11 RL12 RL16
    @(negedge i_sclk) disable iff (!lrst_n)
    s_read_header |=> (lnk_r.st == ST_READ && o_data_oe) [*8] ##1 lnk_r.st == ST_IDLE)
    else $error("read data phase not eight clocks");

  a_release_idle: assert property ( // see RL13
    @(negedge i_sclk) disable iff (!lrst_n)
    (lnk_r.st != ST_READ && $past(lnk_r.st) != ST_READ) |-> !o_data_oe)
    else $error("data pin still driven outside a read");

  // Checks in the core domain, apart from the link-domain frame span check
  a_soft_core: assert property ( // see RL4
    @(posedge i_clk) disable iff (!i_rstn)
    soft_evt |=> (!o_core_rst_n && o_cal_start) ##1 (!o_core_rst_n && !o_cal_start))
    else $error("soft reset pulse or calibration start missing");

  a_sleep_entry: assert property ( // see RL9
    @(posedge i_clk) disable iff (!i_rstn)
    (soft_evt || stop_done) |=> o_sleep && !o_tx_active)
    else $error("sleep not entered");

  a_edge_start: assert property ( // see RL2
    @(posedge i_clk) disable iff (!i_rstn)
    o_tx_start |-> !$past(xs[1]) && o_tx_active && !o_sleep)
    else $error("transmit started while port enabled");

  // Frames span sixteen falling edges, whatever the word turns out to be
  sequence s_frame_open;
    lnk_r.st == ST_IDLE && i_data;
  endsequence

  sequence s_frame_close;
    frame_done || (lnk_r.st == ST_READ && lnk_r.cnt == FRAME_LAST_BIT);
  endsequence

  a_frame_span: assert property ( // see RL11
    @(negedge i_sclk) disable iff (!lrst_n)
    s_frame_open |=> ##14 s_frame_close)
    else $error("frame did not last sixteen clocks");

  sequence s_core_held;
    !o_core_rst_n [*4] ##1 o_core_rst_n;
  endsequence

  a_core_rst_len: assert property ( // see RL4
    @(posedge i_clk) disable iff (!i_rstn)
    $fell(o_core_rst_n) |-> s_core_held)
    else $error("core reset pulse length wrong");

  a_write_pulse: assert property ( // see RL15
    @(posedge i_clk) disable iff (!i_rstn)
    wr_evt |=> o_reg_wr ##1 !o_reg_wr)
    else $error("write pulse missing or too long");

  a_refuse_edge: assert property ( // see RL2
    @(posedge i_clk) disable iff (!i_rstn)
    (xs[1] || cor_r.active) |=> !o_tx_start)
    else $error("transmit started while refused");

  a_sleep_hold: assert property ( // see RL9
    @(posedge i_clk) disable iff (!i_rstn)
    (o_sleep && !edge_evt) |=> o_sleep)
    else $error("sleep left without a data edge");

endmodule

// [verilog/two_wire_pkg.sv]
// Constants, states and carriers shared by the two-wire command port.
// Assumes one core clock at 125 MHz and a host-made serial clock.
package two_wire_pkg;

  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int STOP_UNIT_NS = 1000000;
  localparam int STOP_UNIT_CYCLES = STOP_UNIT_NS / CLK_PERIOD_NS;
  localparam logic [2:0] CORE_RST_CYCLES = 3'h4;

  // Frame layout
  localparam logic [4:0] HDR_LAST_BIT = 5'h07;
  localparam logic [4:0] FRAME_LAST_BIT = 5'h0f;
  localparam logic [5:0] RST_LOW_CYCLES = 6'h20;
  localparam int HDR_START_POS = 7;
  localparam int HDR_DIR_POS = 6;

  // Fixed command words
  localparam logic [15:0] CMD_PORT_RST = 16'h8d00;
  localparam logic [15:0] CMD_PORT_OFF = 16'h8d02;
  localparam logic [15:0] CMD_SOFT_RST = 16'hbd01;

  // Reset values
  localparam logic [7:0] REG_RESET_VAL = 8'h00;
  localparam logic [6:0] STOP_MS_RESET = 7'h02;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SHIFT = 3'b010,
    ST_READ = 3'b100
  } link_st_e;

  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] data;
  } reg_wr_s;

  typedef struct packed {
    link_st_e st;
    logic [4:0] cnt;
    logic [14:0] sh;
    logic [5:0] lowrun;
    logic rst_seq;
    logic en;
    logic [7:0] rd_sh;
    logic wr_tgl;
    logic soft_tgl;
    reg_wr_s wr;
    logic [63:0][7:0] regs;
  } link_s;

  typedef struct packed {
    logic oe;
    logic dout;
  } pin_s;

  typedef struct packed {
    logic wr_q;
    logic soft_q;
    logic data_q;
    logic [2:0] rst_cnt;
    logic [16:0] unit_cnt;
    logic [6:0] ms_cnt;
    logic active;
    logic sleep;
    logic tx_start;
    logic cal_start;
    logic reg_wr;
    reg_wr_s wr;
  } core_s;

endpackage

// [verilog/sync_2ff.sv]
// Two-flop synchroniser for level and toggle signals.
// Assumes inputs are stable levels or toggles slower than two destination clocks.
`timescale 1ns/10ps
module sync_2ff #(
  parameter int W = 1
) (
  // Destination clock
  input wire logic i_clk,
  // Asynchronous levels in, synchronised levels out
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  always_ff @(posedge i_clk) begin
    meta_r <= i_d;
    q_r <= meta_r;
  end

  assign o_q = q_r;

endmodule

// [dv/host_model.sv]
// Host side of the two-wire port: makes the serial clock and drives data.
// Assumes one caller at a time; the bench resolves the pin level.
`timescale 1ns/10ps
module host_model #(
  parameter int WAIT_NS = 1000000,
  parameter int FIRST_CLK_EDGE_DELAY_NS = 20
) (
  // Serial link
  output logic o_sclk,
  output logic o_data,
  output logic o_data_oe,
  input wire logic i_pin
);
  initial begin
    o_sclk = 1'b1;
    o_data = 1'b0;
    o_data_oe = 1'b1;
  end
  // Data moves only just after a rising edge
  task automatic send(input logic [47:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      #1 o_data = v[i];
      #14 o_sclk = 1'b0;
      #15 o_sclk = 1'b1;
    end
    #1 o_data = 1'b0;
  endtask
  // Data goes low well before the first falling clock edge
  task automatic port_reset();
    o_data = 1'b0;
    #(FIRST_CLK_EDGE_DELAY_NS);
    send({32'h0, 16'h8d00}, 48);
  endtask
  task automatic port_off();
    send(48'h8d02, 16);
  endtask
  // Long quiet wait so the core settles before anything else
  task automatic soft_reset();
    send(48'hbd01, 16);
    #(WAIT_NS);
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    send({32'h0, 2'b10, a, d}, 16);
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    send({40'h0, 2'b11, a}, 8);
    o_data_oe = 1'b0;
    for (int i = 0; i < 8; i++) begin
      #14 o_sclk = 1'b0;
      d = {d[6:0], i_pin};
      #15 o_sclk = 1'b1;
    end
    o_data_oe = 1'b1;
  endtask
  task automatic set_pin(input logic v);
    o_data = v;
  endtask
endmodule

// [dv/test_two_wire_port.sv]
// Self-checking bench for the two-wire command port.
// Assumes the host model above and a pull-down on the data pin.
`timescale 1ns/10ps
module test_two_wire_port;
  import two_wire_pkg::*;
  localparam int UNIT = 20;
  logic i_clk, i_rstn, i_start_fall;
  logic [6:0] i_stop_ms;
  logic o_data, o_data_oe, o_reg_wr, o_core_rst_n, o_cal_start, o_port_en;
  logic o_tx_start, o_tx_active, o_sleep, sclk, h_d, h_oe;
  reg_wr_s o_reg, last_reg;
  wire pin = o_data_oe ? o_data : (h_oe ? h_d : 1'b0);
  int err_count, num_checks, wr_cnt, cal_cnt, rst_lo, tx_cnt;
  logic [7:0] rd;

  two_wire_port #(.STOP_UNIT(UNIT)) two_wire_port_inst (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_sclk(sclk), .i_data(pin),
    .o_data(o_data), .o_data_oe(o_data_oe), .i_start_fall(i_start_fall),
    .i_stop_ms(i_stop_ms), .o_reg_wr(o_reg_wr), .o_reg(o_reg),
    .o_core_rst_n(o_core_rst_n), .o_cal_start(o_cal_start), .o_port_en(o_port_en),
    .o_tx_start(o_tx_start), .o_tx_active(o_tx_active), .o_sleep(o_sleep));
  host_model #(.WAIT_NS(2000)) host_model_inst (
    .o_sclk(sclk), .o_data(h_d), .o_data_oe(h_oe), .i_pin(pin));

  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  // Event counters so single-cycle pulses are never missed
  always @(posedge i_clk) begin
    if (o_reg_wr === 1'b1) begin
      wr_cnt++;
      last_reg = o_reg;
    end
    if (o_cal_start === 1'b1) cal_cnt++;
    if (o_core_rst_n === 1'b0) rst_lo++;
    if (o_tx_start === 1'b1) tx_cnt++;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic t_enable();
    host_model_inst.port_reset();
    cyc(10);
    chk(16'(o_port_en), 16'h1);
  endtask
  task automatic t_write_read();
    host_model_inst.wr(6'h12, 8'haa);
    cyc(10);
    chk(16'(wr_cnt), 16'h1);
    chk(16'(last_reg), {2'h0, 6'h12, 8'haa});
    host_model_inst.wr(6'h3f, 8'h5a);
    host_model_inst.rd(6'h3f, rd);
    chk(16'(rd), 16'h5a);
    host_model_inst.rd(6'h12, rd);
    chk(16'(rd), 16'haa);
    host_model_inst.rd(6'h2a, rd);
    chk(16'(rd), 16'(REG_RESET_VAL));
    cyc(1);
    chk(16'(o_data_oe), 16'h0);
  endtask
  task automatic t_soft();
    host_model_inst.soft_reset();
    chk(16'(cal_cnt), 16'h1);
    chk(16'(rst_lo), 16'(CORE_RST_CYCLES));
    chk(16'(o_sleep), 16'h1);
    chk(16'(o_port_en), 16'h1);
    host_model_inst.rd(6'h12, rd);
    chk(16'(rd), 16'(REG_RESET_VAL));
  endtask
  // Port reset bits may start a transmission while off, so count from here
  task automatic t_off_tx();
    int tx0;
    host_model_inst.port_off();
    cyc(10);
    chk(16'(o_port_en), 16'h0);
    tx0 = tx_cnt;
    host_model_inst.set_pin(1'b1);
    cyc(10);
    chk(16'(tx_cnt - tx0), 16'h1);
    chk({o_tx_active, o_sleep}, 16'h2);
    host_model_inst.set_pin(1'b0);
    cyc(UNIT / 2);
    chk(16'(o_tx_active), 16'h1);
    cyc(UNIT + 10);
    chk({o_tx_active, o_sleep}, 16'h1);
    t_enable();
  endtask
  task automatic t_fall_tx();
    int tx0;
    i_start_fall = 1'b1;
    i_stop_ms = 7'h02;
    host_model_inst.port_off();
    cyc(10);
    tx0 = tx_cnt;
    host_model_inst.set_pin(1'b1);
    cyc(10);
    chk(16'(tx_cnt - tx0), 16'h0);
    host_model_inst.set_pin(1'b0);
    cyc(10);
    chk(16'(tx_cnt - tx0), 16'h1);
    cyc(UNIT);
    chk({o_tx_active, o_sleep}, 16'h2);
    cyc(UNIT);
    chk({o_tx_active, o_sleep}, 16'h1);
    i_start_fall = 1'b0;
    i_stop_ms = 7'h01;
    t_enable();
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #200000;
    err_count++;
    tally_and_finish();
  end
  initial begin
    i_rstn = 1'b0;
    i_start_fall = 1'b0;
    i_stop_ms = 7'h01;
    fork
      host_model_inst.send(48'h0, 4);
      repeat (20) @(posedge i_clk);
    join
    #1 i_rstn = 1'b1;
    // Serial side leaves reset only after two more falling edges
    host_model_inst.send(48'h0, 4);
    cyc(4);
    chk(16'(o_sleep), 16'h1);
    t_enable();
    t_write_read();
    t_soft();
    t_off_tx();
    t_fall_tx();
    tally_and_finish();
  end
endmodule
